// ### rtl/battery_monitor_fault_diagnostics.sv
// fault diagnostics unit of a twelve-cell monitor with an apb register port
// assumes scan results arrive as one-cycle valid strobes from the measurement path
`timescale 1ns/1ps
`default_nettype none
`include "diag_regs.svh"

// Operation
// - programmable undervoltage limit, full scale 14'h3fff is 5 V, compared per cell.
// - filter sample-count field resets to 3'b011, eight samples.
// - mask bit zero means cell present; absent cells skip undervoltage test.
// - undervoltage flagged only after programmed run of consecutive low samples.
// - first fault into an empty status register sends an unprompted report.
// - filter run restarts on changed count field or a passing sample.
// - open supply or ground flagged after programmed run of open samples.
// - supply filter restarts on pass; cleared only in fault status.
// - scan current select one gives 1 mA, zero gives 150 uA.
// - open-wire test skips masked inputs two to twelve; zero, one always tested.
// - scan-wires command runs to completion and logs open wires.
// - programmable temperature limit, full scale 14'h3fff is 2.5 V.
// - four enable bits choose which temperature inputs are checked.
// - enabled temperature input below limit faults at once, unfiltered.
// - three readable coefficients; reference reading updated during temperature scan.
// - calculate command stores checksum over configuration page.
// - check command recomputes and sets mismatch flag when different.
// - writing zero clears fault status once detail registers are clear.
// - active-low fault output low while any status bit is set.
module battery_monitor_fault_diagnostics #(
   parameter int CELL_COUNT = 12,
   parameter logic [13:0] COEF_A = 14'h0000,
   parameter logic [13:0] COEF_B = 14'h0000,
   parameter logic [13:0] COEF_C = 14'h0000
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cell_sample_valid,
   input wire logic [3:0] cell_sample_index,
   input wire logic [13:0] cell_sample_value,
   input wire logic supply_sample_valid,
   input wire logic supply_open,
   input wire logic wire_scan_done,
   input wire logic [12:0] wire_open,
   input wire logic temp_sample_valid,
   input wire logic [1:0] temp_sample_index,
   input wire logic [13:0] temp_sample_value,
   input wire logic ref_sample_valid,
   input wire logic [13:0] ref_sample_value,
   output logic scan_volt_req,
   output logic scan_wire_req,
   output logic scan_temp_req,
   output logic scan_current_select,
   output logic fault_report,
   output logic [13:0] fault_report_data,
   output logic fault_n
);
   import diag_pkg::*;

   // refuse cell counts the mask layout cannot serve
   if (CELL_COUNT != 12) begin : g_count_check
      $error("cell count must be 12");
   end

   diag_state_s cur;
   diag_state_s next_state;
   logic [CELL_COUNT-1:0] cell_hit;
   logic supply_hit;
   logic [CELL_COUNT-1:0] cell_low;
   logic [CELL_COUNT-1:0] cell_valid;

   // checksum over configuration page, shared by calculate and check
   function automatic logic [13:0] page_checksum(input diag_state_s s);
      logic [13:0] acc;
      acc = s.uv_limit;
      acc = {acc[12:0], acc[13]} ^ {7'h00, s.temp_test_enable, s.fault_filter_count_bits};
      acc = {acc[12:0], acc[13]} ^ {2'h0, s.cell_absent};
      acc = {acc[12:0], acc[13]} ^ {13'h0000, s.scan_current_select};
      acc = {acc[12:0], acc[13]} ^ s.temp_limit;
      return acc;
   endfunction : page_checksum

   // decodes a register offset, used for both read and write
   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction : reg_hit

   genvar gi;
   generate
      for (gi = 0; gi < CELL_COUNT; gi++) begin : g_cell
         // cell index 1..12 maps onto mask bit index-1
         assign cell_valid[gi] = cell_sample_valid
                                 && cell_sample_index == 4'(gi + 1)
                                 && !cur.cell_absent[gi];
         assign cell_low[gi] = cell_sample_value < cur.uv_limit;
         diag_filter #(.COUNT_WIDTH(8)) u_cell_filter (
            .ref_clk(ref_clk),
            .arst_n(arst_n),
            .restart(cur.filter_restart),
            .sample_valid(cell_valid[gi]),
            .condition(cell_low[gi]),
            .code(cur.fault_filter_count_bits),
            .hit(cell_hit[gi])
         );
      end
   endgenerate

   diag_filter #(.COUNT_WIDTH(8)) u_supply_filter (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .restart(cur.filter_restart),
      .sample_valid(supply_sample_valid),
      .condition(supply_open),
      .code(cur.fault_filter_count_bits),
      .hit(supply_hit)
   );

   always_comb begin
      logic setup;
      logic wr;
      logic [4:0] set_bits;
      logic [12:0] wire_log;
      logic [13:0] csum_now;
      setup = psel && !penable;
      wr = psel && penable && cur.pready && pwrite;
      set_bits = 5'h00;
      wire_log = 13'h0000;
      csum_now = page_checksum(cur);
      next_state = cur;
      next_state.scan_volt_req = 1'b0;
      next_state.scan_wire_req = 1'b0;
      next_state.scan_temp_req = 1'b0;
      next_state.fault_report = 1'b0;
      next_state.filter_restart = 1'b0;
      next_state.pready = setup;
      next_state.pslverr = 1'b0;

      // apb read data and unmapped check at setup
      if (setup) begin
         next_state.prdata = 32'h0000_0000;
         if (reg_hit(paddr, `UV_LIMIT_OFS)) begin
            next_state.prdata = {18'h00000, cur.uv_limit};
         end else if (reg_hit(paddr, `FAULT_SETUP_OFS)) begin
            next_state.prdata = {24'h000000, cur.temp_test_enable, 1'b0,
                                 cur.fault_filter_count_bits};
         end else if (reg_hit(paddr, `CELL_SETUP_OFS)) begin
            next_state.prdata = {20'h00000, cur.cell_absent};
         end else if (reg_hit(paddr, `DEVICE_SETUP_OFS)) begin
            next_state.prdata = {31'h00000000, cur.scan_current_select};
         end else if (reg_hit(paddr, `TEMP_LIMIT_OFS)) begin
            next_state.prdata = {18'h00000, cur.temp_limit};
         end else if (reg_hit(paddr, `FAULT_STATUS_OFS)) begin
            next_state.prdata = {27'h0000000, cur.status};
         end else if (reg_hit(paddr, `UV_FAULT_OFS)) begin
            next_state.prdata = {20'h00000, cur.uv_fault};
         end else if (reg_hit(paddr, `WIRE_FAULT_OFS)) begin
            next_state.prdata = {19'h00000, cur.wire_fault};
         end else if (reg_hit(paddr, `TEMP_FAULT_OFS)) begin
            next_state.prdata = {28'h0000000, cur.temp_fault};
         end else if (reg_hit(paddr, `REF_VOLTAGE_OFS)) begin
            next_state.prdata = {18'h00000, cur.ref_voltage};
         end else if (reg_hit(paddr, `COEF_A_OFS)) begin
            next_state.prdata = {18'h00000, COEF_A};
         end else if (reg_hit(paddr, `COEF_B_OFS)) begin
            next_state.prdata = {18'h00000, COEF_B};
         end else if (reg_hit(paddr, `COEF_C_OFS)) begin
            next_state.prdata = {18'h00000, COEF_C};
         end else if (reg_hit(paddr, `COMMAND_OFS)) begin
            next_state.prdata = {31'h00000000, cur.wire_scan == WIRE_BUSY};
         end else if (reg_hit(paddr, `CHECKSUM_OFS)) begin
            next_state.prdata = {18'h00000, cur.checksum};
         end else begin
            next_state.pslverr = 1'b1;
         end
      end else begin
         next_state.pslverr = cur.pslverr && !(psel && penable && cur.pready);
      end

      // register writes take effect at the completing edge
      if (wr) begin
         if (reg_hit(paddr, `UV_LIMIT_OFS)) begin
            next_state.uv_limit = pwdata[13:0];
         end else if (reg_hit(paddr, `FAULT_SETUP_OFS)) begin
            next_state.fault_filter_count_bits = pwdata[`FILT_LSB+:3];
            next_state.temp_test_enable = pwdata[`TEMP_EN_LSB+:4];
            next_state.filter_restart =
               pwdata[`FILT_LSB+:3] != cur.fault_filter_count_bits;
         end else if (reg_hit(paddr, `CELL_SETUP_OFS)) begin
            next_state.cell_absent = pwdata[11:0];
         end else if (reg_hit(paddr, `DEVICE_SETUP_OFS)) begin
            next_state.scan_current_select = pwdata[0];
         end else if (reg_hit(paddr, `TEMP_LIMIT_OFS)) begin
            next_state.temp_limit = pwdata[13:0];
         end else if (reg_hit(paddr, `UV_FAULT_OFS)) begin
            next_state.uv_fault = cur.uv_fault & pwdata[11:0];
         end else if (reg_hit(paddr, `WIRE_FAULT_OFS)) begin
            next_state.wire_fault = cur.wire_fault & pwdata[12:0];
         end else if (reg_hit(paddr, `TEMP_FAULT_OFS)) begin
            next_state.temp_fault = cur.temp_fault & pwdata[3:0];
         end else if (reg_hit(paddr, `FAULT_STATUS_OFS)) begin
            // a status bit only drops once its detail register is empty
            next_state.status = cur.status & pwdata[4:0];
            next_state.status[`ST_UV] = cur.status[`ST_UV]
               & (pwdata[`ST_UV] | (cur.uv_fault != 12'h000));
            next_state.status[`ST_WIRE] = cur.status[`ST_WIRE]
               & (pwdata[`ST_WIRE] | (cur.wire_fault != 13'h0000));
            next_state.status[`ST_TEMP] = cur.status[`ST_TEMP]
               & (pwdata[`ST_TEMP] | (cur.temp_fault != 4'h0));
         end else if (reg_hit(paddr, `COMMAND_OFS)) begin
            next_state.scan_volt_req = pwdata[`CMD_SCAN_V];
            next_state.scan_temp_req = pwdata[`CMD_SCAN_T];
            if (pwdata[`CMD_SCAN_W] && cur.wire_scan == WIRE_IDLE) begin
               next_state.scan_wire_req = 1'b1;
               next_state.wire_scan = WIRE_BUSY;
            end
            if (pwdata[`CMD_CALC]) begin
               next_state.checksum = csum_now;
            end else if (pwdata[`CMD_CHECK] && csum_now != cur.checksum) begin
               set_bits[`ST_CSUM] = 1'b1;
            end
         end
      end

      // undervoltage detail bits and supply status bit
      if (cell_hit != 12'h000) begin
         next_state.uv_fault = next_state.uv_fault | cell_hit;
         set_bits[`ST_UV] = 1'b1;
      end
      if (supply_hit) begin
         set_bits[`ST_SUPPLY] = 1'b1;
      end

      // open-wire scan completion
      case (cur.wire_scan)
         WIRE_IDLE: begin
         end
         WIRE_BUSY: begin
            if (wire_scan_done) begin
               wire_log = wire_open & {~cur.cell_absent[11:1], 2'b11};
               next_state.wire_fault = next_state.wire_fault | wire_log;
               set_bits[`ST_WIRE] = wire_log != 13'h0000;
               next_state.wire_scan = WIRE_IDLE;
            end
         end
         default: next_state.wire_scan = WIRE_IDLE;
      endcase

      // temperature inputs, no filtering
      if (temp_sample_valid && cur.temp_test_enable[temp_sample_index]
          && temp_sample_value < cur.temp_limit) begin
         next_state.temp_fault[temp_sample_index] = 1'b1;
         set_bits[`ST_TEMP] = 1'b1;
      end
      if (ref_sample_valid) begin
         next_state.ref_voltage = ref_sample_value;
      end

      // set wins over a same-cycle clear
      next_state.status = next_state.status | set_bits;
      next_state.fault_report = (set_bits != 5'h00) && (cur.status == 5'h00);
      next_state.fault_n = next_state.status == 5'h00;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur <= '0;
         cur.uv_limit <= `UV_LIMIT_RESET;
         cur.fault_filter_count_bits <= `FILT_RESET;
         cur.temp_limit <= `TEMP_LIMIT_RESET;
         cur.scan_current_select <= `SCAN_CUR_RESET;
         cur.wire_scan <= WIRE_IDLE;
         cur.fault_n <= 1'b1;
      end else begin
         cur <= next_state;
      end
   end

   assign prdata = cur.prdata;
   assign pready = cur.pready;
   assign pslverr = cur.pslverr;
   assign scan_volt_req = cur.scan_volt_req;
   assign scan_wire_req = cur.scan_wire_req;
   assign scan_temp_req = cur.scan_temp_req;
   assign scan_current_select = cur.scan_current_select;
   assign fault_report = cur.fault_report;
   // status copy, valid with the report pulse
   assign fault_report_data = {9'h000, cur.status};
   assign fault_n = cur.fault_n;

endmodule : battery_monitor_fault_diagnostics

`default_nettype wire

// ### inc/diag_regs.svh
// register offsets, field positions and reset values of the fault diagnostics unit
// assumes a 32-bit apb slave with one register per aligned word
`ifndef DIAG_REGS_SVH
`define DIAG_REGS_SVH

`define UV_LIMIT_OFS      12'h000
`define FAULT_SETUP_OFS   12'h004
`define CELL_SETUP_OFS    12'h008
`define DEVICE_SETUP_OFS  12'h00c
`define TEMP_LIMIT_OFS    12'h010
`define FAULT_STATUS_OFS  12'h014
`define UV_FAULT_OFS      12'h018
`define WIRE_FAULT_OFS    12'h01c
`define TEMP_FAULT_OFS    12'h020
`define REF_VOLTAGE_OFS   12'h024
`define COEF_A_OFS        12'h028
`define COEF_B_OFS        12'h02c
`define COEF_C_OFS        12'h030
`define COMMAND_OFS       12'h034
`define CHECKSUM_OFS      12'h038

`define FILT_LSB          0
`define TEMP_EN_LSB       4
`define ST_UV             0
`define ST_SUPPLY         1
`define ST_WIRE           2
`define ST_TEMP           3
`define ST_CSUM           4
`define CMD_SCAN_V        0
`define CMD_SCAN_W        1
`define CMD_SCAN_T        2
`define CMD_CALC          3
`define CMD_CHECK         4

`define FILT_RESET        3'h3
`define UV_LIMIT_RESET    14'h0000
`define TEMP_LIMIT_RESET  14'h0000
`define SCAN_CUR_RESET    1'h1

`endif

// ### inc/diag_pkg.sv
// types shared by the fault diagnostics unit and its sample filter
// assumes diag_regs.svh for numeric constants
package diag_pkg;

   typedef enum logic [0:0] {WIRE_IDLE, WIRE_BUSY} wire_scan_e;

   typedef struct packed {
      logic [7:0] count;
      logic hit;
   } filter_state_s;

   typedef struct packed {
      logic [13:0] uv_limit;
      logic [2:0] fault_filter_count_bits;
      logic [3:0] temp_test_enable;
      logic [11:0] cell_absent;
      logic scan_current_select;
      logic [13:0] temp_limit;
      logic [4:0] status;
      logic [11:0] uv_fault;
      logic [12:0] wire_fault;
      logic [3:0] temp_fault;
      logic [13:0] ref_voltage;
      logic [13:0] checksum;
      wire_scan_e wire_scan;
      logic filter_restart;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic scan_volt_req;
      logic scan_wire_req;
      logic scan_temp_req;
      logic fault_report;
      logic fault_n;
   } diag_state_s;

endpackage : diag_pkg

// ### rtl/diag_filter.sv
// consecutive-sample fault filter: hit on the nth sample in a row and on each one after
// assumes samples synchronous to ref_clk, restart clears the run
`timescale 1ns/1ps
`default_nettype none

module diag_filter #(
   parameter int COUNT_WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic restart,
   input wire logic sample_valid,
   input wire logic condition,
   input wire logic [2:0] code,
   output logic hit
);
   import diag_pkg::*;

   if (COUNT_WIDTH != 8) begin : g_width_check
      $error("diag_filter: count width must be 8");
   end

   filter_state_s cur;
   filter_state_s nxt;
   logic [7:0] need;

   always_comb begin
      need = 8'h01 << code;
      nxt = cur;
      nxt.hit = 1'b0;
      if (restart) begin
         nxt.count = 8'h00;
      end else if (sample_valid) begin
         if (!condition) begin
            nxt.count = 8'h00;
         end else if (cur.count + 8'h01 >= need) begin
            nxt.count = need;
            nxt.hit = 1'b1;
         end else begin
            nxt.count = cur.count + 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur <= '0;
      end else begin
         cur <= nxt;
      end
   end

   assign hit = cur.hit;

endmodule : diag_filter

`default_nettype wire

// ### dv/diag_props.sv
// port checker for the fault diagnostics unit
// assumes bind onto the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "diag_regs.svh"
module diag_props (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic cell_sample_valid,
   input wire logic supply_sample_valid,
   input wire logic wire_scan_done,
   input wire logic temp_sample_valid,
   input wire logic scan_wire_req,
   input wire logic scan_current_select,
   input wire logic fault_report,
   input wire logic [13:0] fault_report_data,
   input wire logic fault_n
);
   logic acc;
   logic ev;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   assign acc = psel && penable && pready && pwrite;
   assign ev = cell_sample_valid || supply_sample_valid || temp_sample_valid
      || wire_scan_done || (acc && paddr == `COMMAND_OFS);
   a_answer_next: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_wire_req_cause: assert property (
      scan_wire_req |-> $past(acc && paddr == `COMMAND_OFS && pwdata[`CMD_SCAN_W]))
      else $error("wire scan without command");
   a_cur_only_write: assert property (
      $changed(scan_current_select) |-> $past(acc && paddr == `DEVICE_SETUP_OFS))
      else $error("scan current moved without write");
   a_cur_value: assert property (
      $past(acc && paddr == `DEVICE_SETUP_OFS) |-> scan_current_select == $past(pwdata[0]))
      else $error("scan current not written value");
   a_report_first: assert property (fault_report |-> $past(fault_n) && !fault_n)
      else $error("report without empty status");
   a_report_data: assert property (fault_report |-> fault_report_data != 14'h0)
      else $error("report carries no fault");
   a_fault_hold: assert property (
      !fault_n && !(acc && paddr == `FAULT_STATUS_OFS) |=> !fault_n)
      else $error("fault output released early");
   a_fault_cause: assert property (
      $fell(fault_n) |-> $past(ev, 1) || $past(ev, 2) || $past(ev, 3))
      else $error("fault without sample");
   a_clear_write: assert property ($rose(fault_n) |-> $past(acc && paddr == `FAULT_STATUS_OFS))
      else $error("fault cleared without write");
   c_report: cover property (fault_report);
   c_wire: cover property (scan_wire_req);
   c_clear: cover property ($rose(fault_n));
endmodule : diag_props
bind battery_monitor_fault_diagnostics diag_props diag_props_i (.ref_clk, .arst_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .cell_sample_valid, .supply_sample_valid,
   .wire_scan_done, .temp_sample_valid, .scan_wire_req, .scan_current_select, .fault_report,
   .fault_report_data, .fault_n);
`default_nettype wire

// ### dv/meas_model.sv
// measurement path model answering scan requests
// assumes one-cycle request pulses sampled at rising edges
`timescale 1ns/1ps
`default_nettype none
module meas_model #(
   parameter logic [13:0] LIM = 14'h1000,
   parameter logic [13:0] REFV = 14'h1a5c
) (
   input wire logic ref_clk,
   input wire logic scan_volt_req,
   input wire logic scan_wire_req,
   input wire logic scan_temp_req,
   input wire logic [11:0] low_cells,
   input wire logic open_in,
   input wire logic [12:0] open_wires,
   output logic idle,
   output logic cell_sample_valid,
   output logic [3:0] cell_sample_index,
   output logic [13:0] cell_sample_value,
   output logic supply_sample_valid,
   output logic supply_open,
   output logic wire_scan_done,
   output logic [12:0] wire_open,
   output logic temp_sample_valid,
   output logic [1:0] temp_sample_index,
   output logic [13:0] temp_sample_value,
   output logic ref_sample_valid,
   output logic [13:0] ref_sample_value
);
   initial begin
      idle = 1'b1;
      {cell_sample_valid, cell_sample_index, cell_sample_value, supply_sample_valid,
         supply_open, wire_scan_done, wire_open, temp_sample_valid, temp_sample_index,
         temp_sample_value, ref_sample_valid, ref_sample_value} = '0;
      forever begin
         @(posedge ref_clk);
         if (scan_volt_req) begin
            idle <= 1'b0;
            for (int i = 1; i <= 12; i++) begin
               cell_sample_valid <= 1'b1;
               cell_sample_index <= 4'(i);
               cell_sample_value <= low_cells[i-1] ? LIM - 14'h1 : LIM;
               supply_sample_valid <= (i == 12);
               supply_open <= open_in;
               @(posedge ref_clk);
            end
            cell_sample_valid <= 1'b0;
            supply_sample_valid <= 1'b0;
            cell_sample_value <= ~cell_sample_value;
            supply_open <= ~supply_open;
            idle <= 1'b1;
         end
         if (scan_wire_req) begin
            idle <= 1'b0;
            repeat (8) @(posedge ref_clk);
            wire_scan_done <= 1'b1;
            wire_open <= open_wires;
            @(posedge ref_clk);
            wire_scan_done <= 1'b0;
            wire_open <= ~open_wires;
            idle <= 1'b1;
         end
         if (scan_temp_req) begin
            idle <= 1'b0;
            for (int i = 0; i < 4; i++) begin
               temp_sample_valid <= 1'b1;
               temp_sample_index <= 2'(i);
               temp_sample_value <= LIM - 14'h1;
               @(posedge ref_clk);
            end
            temp_sample_valid <= 1'b0;
            temp_sample_value <= ~temp_sample_value;
            ref_sample_valid <= 1'b1;
            ref_sample_value <= REFV;
            @(posedge ref_clk);
            ref_sample_valid <= 1'b0;
            ref_sample_value <= ~REFV;
            idle <= 1'b1;
         end
      end
   end
endmodule : meas_model
`default_nettype wire

// ### dv/test_battery_monitor_fault_diagnostics.sv
// self-checking bench for the fault diagnostics unit
// assumes meas_model answers the scan requests
`timescale 1ns/1ps
`default_nettype none
`include "diag_regs.svh"
module test_battery_monitor_fault_diagnostics;
   localparam logic [13:0] LIM = 14'h1000;
   localparam logic [13:0] REFV = 14'h1a5c;
   logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, idle, open_in, rerr;
   logic cell_sample_valid, supply_sample_valid, supply_open, wire_scan_done;
   logic temp_sample_valid, ref_sample_valid, scan_volt_req, scan_wire_req;
   logic scan_temp_req, scan_current_select, fault_report, fault_n;
   logic [11:0] paddr, low;
   logic [31:0] pwdata, prdata, rdata;
   logic [12:0] opens, wire_open;
   logic [3:0] cell_sample_index;
   logic [1:0] temp_sample_index;
   logic [13:0] cell_sample_value, temp_sample_value, ref_sample_value;
   logic [13:0] fault_report_data, rep_data;
   logic [7:0] rep_cnt = 8'h0;
   int n_mismatch, cmp_count;
   battery_monitor_fault_diagnostics #(.COEF_A(14'h0011), .COEF_B(14'h0022),
      .COEF_C(14'h0033)) battery_monitor_fault_diagnostics_i (.ref_clk, .arst_n, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cell_sample_valid,
      .cell_sample_index, .cell_sample_value, .supply_sample_valid, .supply_open,
      .wire_scan_done, .wire_open, .temp_sample_valid, .temp_sample_index,
      .temp_sample_value, .ref_sample_valid, .ref_sample_value, .scan_volt_req,
      .scan_wire_req, .scan_temp_req, .scan_current_select, .fault_report,
      .fault_report_data, .fault_n);
   meas_model #(.LIM(LIM), .REFV(REFV)) meas_model_i (.ref_clk, .scan_volt_req,
      .scan_wire_req, .scan_temp_req, .low_cells(low), .open_in, .open_wires(opens), .idle,
      .cell_sample_valid, .cell_sample_index, .cell_sample_value, .supply_sample_valid,
      .supply_open, .wire_scan_done, .wire_open, .temp_sample_valid, .temp_sample_index,
      .temp_sample_value, .ref_sample_valid, .ref_sample_value);
   initial ref_clk = 1'b0;
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (fault_report === 1'b1) begin
         rep_cnt <= rep_cnt + 8'h1;
         rep_data <= fault_report_data;
      end
   end
   task automatic complete_run();
      $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         n_mismatch++;
         complete_run();
      end
   endtask : xfer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdata, e);
   endtask : rd
   task automatic wait_idle();
      int n;
      n = 0;
      while ((n < 3 || !idle) && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 100) begin
         n_mismatch++;
         complete_run();
      end
      repeat (3) @(posedge ref_clk);
   endtask : wait_idle
   task automatic scan(input logic [31:0] cmd);
      wr(`COMMAND_OFS, cmd);
      wait_idle();
   endtask : scan
   initial begin
      {arst_n, psel, penable, pwrite, open_in} = '0;
      paddr = 12'h0;
      pwdata = 32'h0;
      low = 12'h0;
      opens = 13'h0;
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(`FAULT_SETUP_OFS, 32'h3);
      rd(`DEVICE_SETUP_OFS, 32'h1);
      rd(`UV_LIMIT_OFS, 32'h0);
      rd(`COEF_B_OFS, 32'h22);
      xfer(1'b0, 12'h0fc, 32'h0);
      chk(rerr, 1'b1);
      wr(`UV_LIMIT_OFS, {18'h0, LIM});
      wr(`FAULT_SETUP_OFS, 32'h52);
      wr(`CELL_SETUP_OFS, 32'h4);
      low = 12'h016;
      open_in = 1'b1;
      repeat (3) scan(32'h1);
      chk(fault_n, 1'b1);
      low = 12'h006;
      scan(32'h1);
      rd(`UV_FAULT_OFS, 32'h2);
      rd(`FAULT_STATUS_OFS, 32'h3);
      chk(rep_cnt, 8'h1);
      chk(rep_data, 14'h1);
      wr(`FAULT_STATUS_OFS, 32'h0);
      rd(`FAULT_STATUS_OFS, 32'h1);
      chk(fault_n, 1'b0);
      wr(`UV_FAULT_OFS, 32'h0);
      wr(`FAULT_STATUS_OFS, 32'h0);
      chk(fault_n, 1'b1);
      wr(`DEVICE_SETUP_OFS, 32'h0);
      chk(scan_current_select, 1'b0);
      wr(`CELL_SETUP_OFS, 32'h801);
      opens = 13'h1fff;
      wr(`COMMAND_OFS, 32'h2);
      rd(`COMMAND_OFS, 32'h1);
      wait_idle();
      rd(`COMMAND_OFS, 32'h0);
      rd(`WIRE_FAULT_OFS, 32'h0fff);
      chk(rep_data, 14'h4);
      wr(`TEMP_LIMIT_OFS, {18'h0, LIM});
      scan(32'h4);
      rd(`TEMP_FAULT_OFS, 32'h5);
      rd(`REF_VOLTAGE_OFS, {18'h0, REFV});
      rd(`FAULT_STATUS_OFS, 32'hc);
      chk(rep_cnt, 8'h2);
      wr(`TEMP_FAULT_OFS, 32'h0);
      wr(`WIRE_FAULT_OFS, 32'h0);
      wr(`FAULT_STATUS_OFS, 32'h0);
      wr(`COMMAND_OFS, 32'h8);
      wr(`COMMAND_OFS, 32'h10);
      rd(`FAULT_STATUS_OFS, 32'h0);
      wr(`UV_LIMIT_OFS, 32'h1001);
      wr(`COMMAND_OFS, 32'h10);
      rd(`FAULT_STATUS_OFS, 32'h10);
      chk(fault_n, 1'b0);
      wr(`UV_LIMIT_OFS, {18'h0, LIM});
      rd(`UV_LIMIT_OFS, {18'h0, LIM});
      wr(`COMMAND_OFS, 32'h8);
      wr(`FAULT_STATUS_OFS, 32'h0);
      wr(`COMMAND_OFS, 32'h10);
      rd(`FAULT_STATUS_OFS, 32'h0);
      complete_run();
   end
endmodule : test_battery_monitor_fault_diagnostics
`default_nettype wire
